// ---- src/arx_pkg.sv ----
`default_nettype none
// Shared constants of the audio routing core.
package arx_pkg;
   // Sample width in bits, two's complement.
   localparam int SW = 24;
   // Channel counts of the internal bus and of each source kind.
   localparam int NBUS = 16;
   localparam int NAES = 16;
   localparam int NPAIR = 8;
   localparam int NANA = 4;
   // Sources: 16 de-embedded, then 16 AES, then 4 analog.
   localparam int NSRC = 36;
   // Destinations: 16 embed, then 16 AES, then 4 analog.
   localparam int NDST = 36;
   // AES plus analog channels that carry a node assignment.
   localparam int NNODE = 20;
   // Select field widths of the input and output crosspoints.
   localparam int ISW = 6;
   localparam int OSW = 5;
   // Down mixer gain width and its fraction bits.
   localparam int GW = 16;
   localparam int GFRAC = 14;
   localparam int NDM = 5;
   localparam int DSW = 4;
   // Buffer depth for the rate-aligned AES words.
   localparam int FIFO_DEPTH = 16;
   // Silent samples before a channel is reported absent.
   localparam int METER_HOLD = 2048;
   // Register byte offsets.
   localparam logic [11:0] A_CTRL = 12'h000;
   localparam logic [11:0] A_STATUS = 12'h004;
   localparam logic [11:0] A_MIDX = 12'h008;
   localparam logic [11:0] A_MDATA = 12'h00c;
   localparam logic [11:0] A_INSEL = 12'h040;
   localparam logic [11:0] A_OUTSEL = 12'h080;
   localparam logic [11:0] A_DMSEL = 12'h110;
   localparam logic [11:0] A_DMGAIN = 12'h130;
   localparam logic [11:0] A_NODE = 12'h150;
   // Output select codes beyond the bus channels.
   localparam logic [4:0] OSEL_DML = 5'h10;
   localparam logic [4:0] OSEL_DMR = 5'h11;
   // Gain reset values: unity for L and R, minus 3 dB for the rest.
   localparam logic [15:0] GAIN_UNITY = 16'h4000;
   localparam logic [15:0] GAIN_M3DB = 16'h2d41;
   // Field positions.
   localparam int NODE_DIR_BIT = 1;
   localparam int MD_PRES_BIT = 24;
   // Down mixer input slots.
   localparam int DM_L = 0;
   localparam int DM_R = 1;
   localparam int DM_C = 2;
   localparam int DM_LS = 3;
   localparam int DM_RS = 4;
   // AHB response code.
   localparam logic HRESP_OKAY = 1'b0;
endpackage
`default_nettype wire

// ---- src/arx_fifo_if.sv ----
`timescale 1ns/100ps
`default_nettype none
// Valid/ready carrier between the core and its word buffer.
interface arx_fifo_if #(parameter int W = 8);
   logic         in_valid;  // Filling side offers a word.
   logic         in_ready;  // Buffer can take a word.
   logic [W-1:0] in_data;   // Word offered.
   logic         out_valid; // Head word stands on out_data.
   logic         out_ready; // Drain side takes the head.
   logic [W-1:0] out_data;  // Head word, from a register.
   modport fifo_side (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
   modport user_side (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface // arx_fifo_if
`default_nettype wire

// ---- src/arx_fifo.sv ----
`timescale 1ns/100ps
`default_nettype none
// Word buffer; depth must be a power of two so the pointers wrap freely.
module arx_fifo #(
   parameter int W = 8,
   parameter int D = arx_pkg::FIFO_DEPTH
) (
   // Clock and reset.
   input wire logic      clk,
   input wire logic      rstn,
   // Both sides.
   arx_fifo_if.fifo_side f
);
   localparam int AW = $clog2(D);
   localparam logic [AW:0] DC = (AW+1)'(D);

   // All state, storage included.
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         cnt;
      logic                rdy;
      logic                ov;
      logic [W-1:0]        od;
   } arx_fifo_state_type;

   arx_fifo_state_type r, n;
   logic               push; // Word accepted this cycle.
   logic               pop;  // Head taken this cycle.

   // Head word is read out of a register, so a word written into an
   // empty buffer shows two cycles later; valid is computed to match.
   always_comb begin
      n = r;
      push = f.in_valid && r.rdy;
      pop = f.out_ready && r.ov;
      if (push) begin
         n.mem[r.wp] = f.in_data;
         n.wp = r.wp + 1'b1;
      end
      if (pop) begin
         n.rp = r.rp + 1'b1;
      end
      n.cnt = r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      n.rdy = n.cnt != DC;
      n.ov = r.cnt != {{AW{1'b0}}, pop};
      n.od = r.mem[n.rp];
   end

   // State register; empty and ready out of reset.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r <= '0;
         r.rdy <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign f.in_ready = r.rdy;
   assign f.out_valid = r.ov;
   assign f.out_data = r.od;
endmodule // arx_fifo
`default_nettype wire

// ---- src/arx_meter.sv ----
`timescale 1ns/100ps
`default_nettype none
// Peak and presence meter for one input channel.
module arx_meter #(
   parameter int SW   = arx_pkg::SW,
   parameter int HOLD = arx_pkg::METER_HOLD
) (
   // Clock and reset.
   input  wire logic          clk,
   input  wire logic          rstn,
   // Sample in.
   input  wire logic          stb,
   input  wire logic [SW-1:0] sample,
   input  wire logic          clr,
   // Results.
   output logic      [SW-1:0] peak,
   output logic               present
);
   localparam int CW = $clog2(HOLD + 1);
   localparam logic [CW-1:0] HOLD_C = CW'(HOLD);

   typedef struct packed {
      logic [SW-1:0] peak;
      logic [CW-1:0] quiet;
   } arx_meter_state_type;

   arx_meter_state_type r, n;
   logic [SW-1:0]       mag; // Magnitude; full scale negative fits unsigned.

   assign mag = sample[SW-1] ? SW'(-sample) : sample;

   // A clear arriving with a sample restarts the hold from that sample,
   // so no peak is lost to the read that clears it.
   always_comb begin
      n = r;
      if (stb && (clr || mag > r.peak)) begin
         n.peak = mag;
      end else if (clr) begin
         n.peak = '0;
      end
      if (stb) begin
         n.quiet = (sample != '0) ? '0 : ((r.quiet == HOLD_C) ? HOLD_C : r.quiet + 1'b1);
      end
   end

   // Absent until the first nonzero sample.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r <= '{peak: '0, quiet: HOLD_C};
      end else begin
         r <= n;
      end
   end

   assign peak = r.peak;
   assign present = r.quiet != HOLD_C;
endmodule // arx_meter
`default_nettype wire

// ---- src/arx_core.sv ----
// The placing of the registers and the AHB-Lite register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module arx_core (
   // Clock and reset.
   input  wire logic                                       hclk,
   input  wire logic                                       hresetn,
   // AHB-Lite slave.
   input  wire logic                                       hsel,
   input  wire logic [31:0]                                haddr,
   input  wire logic [1:0]                                 htrans,
   input  wire logic                                       hwrite,
   input  wire logic [2:0]                                 hsize,
   input  wire logic                                       hready,
   input  wire logic [31:0]                                hwdata,
   output logic                                            hreadyout,
   output logic                                            hresp,
   output logic      [31:0]                                hrdata,
   // Sample timing.
   input  wire logic                                       sample_stb,
   output logic                                            sample_out_stb,
   // De-embed banks of both paths.
   input  wire logic [arx_pkg::NBUS-1:0][arx_pkg::SW-1:0]  deemb_a,
   input  wire logic [arx_pkg::NBUS-1:0][arx_pkg::SW-1:0]  deemb_b,
   // Discrete AES inputs.
   input  wire logic [arx_pkg::NAES-1:0][arx_pkg::SW-1:0]  aes_in,
   input  wire logic                                       aes_valid,
   input  wire logic [arx_pkg::NPAIR-1:0]                  aes_nonpcm,
   output logic                                            aes_ready,
   // Analog inputs after conversion.
   input  wire logic [arx_pkg::NANA-1:0][arx_pkg::SW-1:0]  ana_in,
   // Embed banks of both paths.
   output logic      [arx_pkg::NBUS-1:0][arx_pkg::SW-1:0]  emb_a,
   output logic      [arx_pkg::NBUS-1:0][arx_pkg::SW-1:0]  emb_b,
   // Discrete outputs and down-mix pair.
   output logic      [arx_pkg::NAES-1:0][arx_pkg::SW-1:0]  aes_out,
   output logic      [arx_pkg::NANA-1:0][arx_pkg::SW-1:0]  ana_out,
   output logic      [arx_pkg::SW-1:0]                     downmix_left_out,
   output logic      [arx_pkg::SW-1:0]                     downmix_right_out
);
   // Local copies of the package sizes keep the expressions short.
   localparam int SW = arx_pkg::SW;
   localparam int NBUS = arx_pkg::NBUS;
   localparam int NAES = arx_pkg::NAES;
   localparam int NSRC = arx_pkg::NSRC;
   localparam int NDST = arx_pkg::NDST;
   localparam int NNODE = arx_pkg::NNODE;
   localparam int ISW = arx_pkg::ISW;
   localparam int OSW = arx_pkg::OSW;
   localparam int GW = arx_pkg::GW;
   localparam int NDM = arx_pkg::NDM;
   localparam int DSW = arx_pkg::DSW;
   localparam int AW = SW + GW + 2;

   // All state of the core.
   typedef struct packed {
      logic                         hready; // Always ready; no wait states.
      logic                         hresp;  // Always OKAY.
      logic [31:0]                  rdata;  // Read data of the data phase.
      logic                         wr;     // A write data phase is due.
      logic [11:0]                  waddr;  // Its byte offset.
      logic                         path;   // Path served by the crosspoints.
      logic [5:0]                   midx;   // Meter shown on the data register.
      logic [NBUS-1:0][ISW-1:0]     isel_sh;
      logic [NBUS-1:0][ISW-1:0]     isel;
      logic [NDST-1:0][OSW-1:0]     osel_sh;
      logic [NDST-1:0][OSW-1:0]     osel;
      logic [NDM-1:0][DSW-1:0]      dsel;
      logic [NDM-1:0][GW-1:0]       gain;
      logic [NNODE-1:0][1:0]        node;   // Bit 1 output node, bit 0 path.
      logic [arx_pkg::NPAIR-1:0]    npcm;   // Pair carries data, not PCM.
      logic [NAES-1:0][SW-1:0]      direct; // Latest AES word, unconverted.
      logic [NAES-1:0][SW-1:0]      held;   // Rate-aligned AES word.
      logic [NBUS-1:0][SW-1:0]      bus;
      logic [SW-1:0]                dml;
      logic [SW-1:0]                dmr;
      logic [NBUS-1:0][SW-1:0]      emb_a;
      logic [NBUS-1:0][SW-1:0]      emb_b;
      logic [NNODE-1:0][SW-1:0]     xout;   // AES outputs, then analog.
      logic                         ostb;
   } arx_core_state_type;

   // Reset state: straight-through routing and a plain stereo fold-down.
   function automatic arx_core_state_type rst_state();
      arx_core_state_type s;
      s = '0;
      s.hready = 1'b1;
      s.hresp = arx_pkg::HRESP_OKAY;
      for (int i = 0; i < NBUS; i++) begin
         s.isel_sh[i] = ISW'(i);
         s.isel[i] = ISW'(i);
      end
      for (int d = 0; d < NDST; d++) begin
         s.osel_sh[d] = OSW'(d % NBUS);
         s.osel[d] = OSW'(d % NBUS);
      end
      for (int k = 0; k < NDM; k++) begin
         s.dsel[k] = DSW'(k);
         s.gain[k] = (k < 2) ? arx_pkg::GAIN_UNITY : arx_pkg::GAIN_M3DB;
      end
      return s;
   endfunction

   localparam arx_core_state_type RST = rst_state();

   // Scale the sum back to sample width and clip at full scale.
   function automatic logic [SW-1:0] sat(input logic signed [AW-1:0] a);
      logic signed [AW-1:0] s;
      s = a >>> arx_pkg::GFRAC;
      if ((s[AW-1:SW-1] == '0) || (s[AW-1:SW-1] == '1)) begin
         sat = s[SW-1:0];
      end else begin
         sat = s[AW-1] ? {1'b1, {(SW-1){1'b0}}} : {1'b0, {(SW-1){1'b1}}};
      end
   endfunction

   arx_core_state_type       r, n;
   logic [NSRC-1:0][SW-1:0]  msrc;  // Received channels, ungated.
   logic [NSRC-1:0][SW-1:0]  mpeak; // Peak per received channel.
   logic [NSRC-1:0]          mpres; // Presence per received channel.
   logic [NSRC-1:0]          mclr;  // Peak clear by a read.

   // AES words queue here and leave one per sample boundary, so a
   // source faster than video timing stalls on aes_ready. A slower one
   // repeats its last word, which is the trade taken for a small core.
   arx_fifo_if #(.W(NAES * SW)) fq ();

   arx_fifo #(
      .W (NAES * SW),
      .D (arx_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk  (hclk),
      .rstn (hresetn),
      .f    (fq)
   );

   assign fq.in_valid = aes_valid;
   assign fq.in_data = aes_in;
   assign fq.out_ready = sample_stb;

   // One meter per received channel.
   for (genvar g = 0; g < NSRC; g++) begin : g_meter
      arx_meter #(
         .SW   (SW),
         .HOLD (arx_pkg::METER_HOLD)
      ) u_meter (
         .clk     (hclk),
         .rstn    (hresetn),
         .stb     (sample_stb),
         .sample  (msrc[g]),
         .clr     (mclr[g]),
         .peak    (mpeak[g]),
         .present (mpres[g])
      );
   end

   // Bus slave, source assembly, crosspoints and down mixer.
   always_comb begin
      logic [NAES-1:0][SW-1:0] aes_src;
      logic [NSRC-1:0][SW-1:0] gsrc;
      logic [NDST-1:0][SW-1:0] ov;
      logic signed [AW-1:0]    acc_l;
      logic signed [AW-1:0]    acc_r;
      logic [31:0]             rd;
      logic [11:0]             a;
      logic                    rd_go;
      n = r;
      aes_src = '0;
      gsrc = '0;
      ov = '0;
      acc_l = '0;
      acc_r = '0;
      rd = '0;
      mclr = '0;
      msrc = '0;
      a = haddr[11:0];
      rd_go = hsel && hready && htrans[1] && !hwrite;
      // Address phase: writes are remembered for their data phase.
      n.wr = hsel && hready && htrans[1] && hwrite;
      if (n.wr) begin
         n.waddr = a;
      end
      // Read data is captured at the address phase edge.
      if (a == arx_pkg::A_CTRL) begin
         rd[0] = r.path;
      end
      if (a == arx_pkg::A_STATUS) begin
         rd = {22'h0, fq.in_ready, fq.out_valid, r.npcm};
      end
      if (a == arx_pkg::A_MIDX) begin
         rd = 32'(r.midx);
      end
      if (a == arx_pkg::A_MDATA) begin
         rd[arx_pkg::MD_PRES_BIT] = mpres[r.midx];
         rd[SW-1:0] = mpeak[r.midx];
      end
      for (int i = 0; i < NBUS; i++) begin
         if (a == arx_pkg::A_INSEL + 12'(4 * i)) rd = 32'(r.isel_sh[i]);
      end
      for (int d = 0; d < NDST; d++) begin
         if (a == arx_pkg::A_OUTSEL + 12'(4 * d)) rd = 32'(r.osel_sh[d]);
      end
      for (int k = 0; k < NDM; k++) begin
         if (a == arx_pkg::A_DMSEL + 12'(4 * k)) rd = 32'(r.dsel[k]);
         if (a == arx_pkg::A_DMGAIN + 12'(4 * k)) rd = 32'(r.gain[k]);
      end
      for (int j = 0; j < NNODE; j++) begin
         if (a == arx_pkg::A_NODE + 12'(4 * j)) rd = 32'(r.node[j]);
      end
      if (rd_go) begin
         n.rdata = rd;
         // Reading the meter data restarts that meter's peak.
         if (a == arx_pkg::A_MDATA) begin
            mclr[r.midx] = 1'b1;
         end
      end
      // Data phase of a write; unmapped offsets are ignored.
      if (r.wr) begin
         if (r.waddr == arx_pkg::A_CTRL) begin
            n.path = hwdata[0];
         end
         if (r.waddr == arx_pkg::A_MIDX && hwdata[5:0] < 6'(NSRC)) begin
            n.midx = hwdata[5:0];
         end
         for (int i = 0; i < NBUS; i++) begin
            if (r.waddr == arx_pkg::A_INSEL + 12'(4 * i)) n.isel_sh[i] = hwdata[ISW-1:0];
         end
         for (int d = 0; d < NDST; d++) begin
            if (r.waddr == arx_pkg::A_OUTSEL + 12'(4 * d)) n.osel_sh[d] = hwdata[OSW-1:0];
         end
         for (int k = 0; k < NDM; k++) begin
            if (r.waddr == arx_pkg::A_DMSEL + 12'(4 * k)) n.dsel[k] = hwdata[DSW-1:0];
            if (r.waddr == arx_pkg::A_DMGAIN + 12'(4 * k)) n.gain[k] = hwdata[GW-1:0];
         end
         for (int j = 0; j < NNODE; j++) begin
            if (r.waddr == arx_pkg::A_NODE + 12'(4 * j)) n.node[j] = hwdata[1:0];
         end
      end
      // Classification and the unconverted word follow every AES word.
      if (aes_valid) begin
         n.direct = aes_in;
         n.npcm = aes_nonpcm;
      end
      if (sample_stb && fq.out_valid) begin
         n.held = fq.out_data;
      end
      // Data pairs skip conversion: repeating or dropping words of a
      // coded stream would corrupt it.
      for (int c = 0; c < NAES; c++) begin
         aes_src[c] = r.npcm[c / 2] ? r.direct[c] : r.held[c];
      end
      // Received channels, in source order.
      for (int i = 0; i < NBUS; i++) begin
         msrc[i] = r.path ? deemb_b[i] : deemb_a[i];
         msrc[NBUS + i] = aes_src[i];
      end
      for (int k = 0; k < arx_pkg::NANA; k++) begin
         msrc[NBUS + NAES + k] = ana_in[k];
      end
      // Discrete channels reach the bus only when set as inputs of this path.
      gsrc = msrc;
      for (int j = 0; j < NNODE; j++) begin
         if (r.node[j] != {1'b0, r.path}) gsrc[NBUS + j] = '0;
      end
      // Output crosspoint values: bus channel, down-mix pair, or silence.
      for (int d = 0; d < NDST; d++) begin
         if (r.osel[d] < OSW'(NBUS)) begin
            ov[d] = r.bus[r.osel[d][3:0]];
         end else if (r.osel[d] == arx_pkg::OSEL_DML) begin
            ov[d] = r.dml;
         end else if (r.osel[d] == arx_pkg::OSEL_DMR) begin
            ov[d] = r.dmr;
         end
      end
      // Left takes L, C, Ls; right takes R, C, Rs.
      acc_l = $signed(r.bus[r.dsel[arx_pkg::DM_L]]) * $signed(r.gain[arx_pkg::DM_L])
            + $signed(r.bus[r.dsel[arx_pkg::DM_C]]) * $signed(r.gain[arx_pkg::DM_C])
            + $signed(r.bus[r.dsel[arx_pkg::DM_LS]]) * $signed(r.gain[arx_pkg::DM_LS]);
      acc_r = $signed(r.bus[r.dsel[arx_pkg::DM_R]]) * $signed(r.gain[arx_pkg::DM_R])
            + $signed(r.bus[r.dsel[arx_pkg::DM_C]]) * $signed(r.gain[arx_pkg::DM_C])
            + $signed(r.bus[r.dsel[arx_pkg::DM_RS]]) * $signed(r.gain[arx_pkg::DM_RS]);
      // Everything audio moves once per sample boundary.
      if (sample_stb) begin
         n.isel = r.isel_sh;
         n.osel = r.osel_sh;
         for (int i = 0; i < NBUS; i++) begin
            n.bus[i] = (r.isel[i] < ISW'(NSRC)) ? gsrc[r.isel[i]] : '0;
         end
         n.dml = sat(acc_l);
         n.dmr = sat(acc_r);
         // The served path embeds the crosspoint; the other passes through.
         for (int i = 0; i < NBUS; i++) begin
            n.emb_a[i] = r.path ? deemb_a[i] : ov[i];
            n.emb_b[i] = r.path ? ov[i] : deemb_b[i];
         end
         // Discrete outputs speak only when set as outputs of this path.
         for (int j = 0; j < NNODE; j++) begin
            n.xout[j] = (r.node[j] == {1'b1, r.path}) ? ov[NBUS + j] : '0;
         end
      end
      n.ostb = sample_stb;
   end

   // State register.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r <= RST;
      end else begin
         r <= n;
      end
   end

   // Outputs straight from the state register; aes_ready from the buffer's register.
   assign hreadyout = r.hready;
   assign hresp = r.hresp;
   assign hrdata = r.rdata;
   assign sample_out_stb = r.ostb;
   assign aes_ready = fq.in_ready;
   assign emb_a = r.emb_a;
   assign emb_b = r.emb_b;
   assign aes_out = r.xout[NAES-1:0];
   assign ana_out = r.xout[NNODE-1:NAES];
   assign downmix_left_out = r.dml;
   assign downmix_right_out = r.dmr;
endmodule // arx_core
`default_nettype wire

// ---- dv/arx_core_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
// Timing checks on the audio side of the routing core, and a check of its bus answer.
module arx_core_chk (
   // Clock, reset and bus answer.
   input wire logic                                      hclk,
   input wire logic                                      hresetn,
   input wire logic                                      hreadyout,
   input wire logic                                      hresp,
   // Stream side.
   input wire logic                                      sample_stb,
   input wire logic                                      sample_out_stb,
   input wire logic                                      aes_valid,
   input wire logic                                      aes_ready,
   input wire logic [arx_pkg::NBUS-1:0][arx_pkg::SW-1:0] emb_a,
   input wire logic [arx_pkg::NBUS-1:0][arx_pkg::SW-1:0] emb_b,
   input wire logic [arx_pkg::NAES-1:0][arx_pkg::SW-1:0] aes_out,
   input wire logic [arx_pkg::NANA-1:0][arx_pkg::SW-1:0] ana_out,
   input wire logic [arx_pkg::SW-1:0]                    downmix_left_out,
   input wire logic [arx_pkg::SW-1:0]                    downmix_right_out
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // A boundary is echoed one cycle later.
   sequence s_echo;
      sample_stb ##1 sample_out_stb;
   endsequence
   a_stb_echo: assert property (sample_stb |-> s_echo) else $error("strobe not echoed");
   a_stb_lone: assert property (!sample_stb |=> !sample_out_stb) else $error("stray strobe");
   a_emb_hold: assert property (!sample_stb |=> $stable(emb_a) && $stable(emb_b)) else $error("embed moved");
   a_aes_hold: assert property (!sample_stb |=> $stable(aes_out)) else $error("aes out moved");
   a_ana_hold: assert property (!sample_stb |=> $stable(ana_out)) else $error("analog out moved");
   a_dm_hold: assert property (!sample_stb |=> $stable({downmix_left_out, downmix_right_out}))
      else $error("downmix moved");
   a_bus_okay: assert property (hreadyout && hresp == arx_pkg::HRESP_OKAY) else $error("bus answer");
   // Ready may only fall in the wake of an accepted word.
   a_ready_keep: assert property (aes_ready && !aes_valid && !$past(aes_valid) |=> aes_ready)
      else $error("ready fell idle");
endmodule // arx_core_chk
`default_nettype wire

// ---- dv/arx_far_end.sv ----
`timescale 1ns/100ps
`default_nettype none
// Far side: sample clock source and an AES source with its own pace.
module arx_far_end (
   // Clock and reset.
   input wire logic                                      clk,
   input wire logic                                      rstn,
   // Requests from the bench.
   input wire logic                                      tick,
   input wire logic                                      push,
   input wire logic [arx_pkg::SW-1:0]                    word,
   // Stream side.
   input wire logic                                      aes_ready,
   output logic                                          sample_stb,
   output logic                                          aes_valid,
   output logic     [arx_pkg::NAES-1:0][arx_pkg::SW-1:0] aes_in
);
   // A word is held until taken; afterwards the lines show its inverse.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sample_stb <= 1'b0;
         aes_valid <= 1'b0;
         aes_in <= '0;
      end else begin
         sample_stb <= tick;
         if (aes_valid && aes_ready) begin
            aes_valid <= 1'b0;
            aes_in <= ~aes_in;
         end else if (push && !aes_valid) begin
            aes_valid <= 1'b1;
            aes_in <= {arx_pkg::NAES{word}};
         end
      end
   end
endmodule // arx_far_end
`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, tick, push, sample_stb, sample_out_stb, aes_valid, aes_ready;
   logic [31:0] haddr, hwdata, hrdata, lfsr_q, r;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [23:0] word, downmix_left_out, downmix_right_out, dml, dmr;
   logic [7:0] aes_nonpcm;
   logic [15:0][23:0] deemb_a, deemb_b, aes_in, emb_a, emb_b, aes_out;
   logic [3:0][23:0] ana_in, ana_out;
   int n_mismatch, checks_done, path, isel[16], osel[16];
   arx_core arx_core_inst(.*, .hready(hreadyout));
   arx_far_end arx_far_end_inst(.*, .clk(hclk), .rstn(hresetn));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Model of one bus channel source.
   function automatic logic [23:0] src(input int s);
      if (s < 16) return path ? deemb_b[s] : deemb_a[s];
      if (path) return 24'h00_0000;
      if (s < 32) return word;
      return s < 36 ? ana_in[s-32] : 24'h00_0000;
   endfunction
   function automatic logic [23:0] out_m(input int o);
      return o < 16 ? src(isel[o]) : o == 16 ? dml : o == 17 ? dmr : 24'h00_0000;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   // One AHB transfer, waiting on ready in each phase.
   task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= 32'(a);
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic stb(input int n);
      repeat (n) begin
         tick <= 1'b1;
         @(posedge hclk);
         tick <= 1'b0;
         repeat (3) @(posedge hclk);
      end
   endtask
   task automatic bank(input int b);
      for (int d = 0; d < 16; d++) chk(b ? emb_b[d] : emb_a[d], out_m(osel[d]));
      $display("bank check done");
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   initial begin
      repeat (6000) @(posedge hclk);
      n_mismatch++;
      $display("[ERR] %0t watchdog", $time);
      final_report;
   end
   initial begin
      {hsel, hwrite, tick, push, path, haddr, htrans, hwdata, word, aes_nonpcm} = '0;
      hsize = 3'b010;
      hresetn = 1'b0;
      lfsr_q = 32'h77ec_9ec3;
      for (int i = 0; i < 16; i++) begin
         lfsr_q = lfsr(lfsr_q);
         {deemb_a[i], deemb_b[i]} = {lfsr_q[23:0], lfsr_q[31:8]};
         ana_in[i%4] = lfsr_q[27:4];
         isel[i] = i;
         osel[i] = i;
      end
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      stb(3);
      bank(0);
      // AES and analog sources on the bus, conversion bypassed.
      aes_nonpcm <= 8'hff;
      word <= 24'h12_3450;
      push <= 1'b1;
      @(posedge hclk);
      push <= 1'b0;
      isel[0] = 19;
      isel[1] = 33;
      osel[2] = 1;
      ahb(1, arx_pkg::A_INSEL, 19);
      ahb(1, arx_pkg::A_INSEL + 4, 33);
      ahb(1, arx_pkg::A_OUTSEL + 8, 1);
      stb(3);
      bank(0);
      ahb(0, arx_pkg::A_STATUS, 0);
      chk(r & 32'hff, 32'hff);
      // Down mix: saturating left, unity right, routed to embed and AES.
      deemb_a[5] <= 24'h60_0000;
      dml = 24'h80_0000;
      ahb(1, arx_pkg::A_DMSEL, 5);
      ahb(1, arx_pkg::A_DMSEL + 4, 6);
      ahb(1, arx_pkg::A_DMGAIN, 32'h0000_8000);
      for (int k = 2; k < 5; k++) ahb(1, arx_pkg::A_DMGAIN + 12'(4*k), 0);
      ahb(1, arx_pkg::A_NODE, 2);
      ahb(1, arx_pkg::A_OUTSEL + 12, 16);
      ahb(1, arx_pkg::A_OUTSEL + 64, 17);
      osel[3] = 16;
      dmr = deemb_a[6];
      stb(4);
      bank(0);
      chk(downmix_left_out, dml);
      chk(downmix_right_out, dmr);
      chk(aes_out[0], dmr);
      // Meter of one input channel, then an unmapped place.
      ahb(1, arx_pkg::A_MIDX, 2);
      ahb(0, arx_pkg::A_CTRL, 0);
      ahb(0, arx_pkg::A_MDATA, 0);
      chk(r & 32'h01ff_ffff, {7'h00, 1'b1, deemb_a[2][23] ? -deemb_a[2] : deemb_a[2]});
      ahb(0, 12'hffc, 0);
      chk(r, 0);
      // Second path served: first path passes straight through.
      ahb(1, arx_pkg::A_OUTSEL + 8, 2);
      ahb(1, arx_pkg::A_OUTSEL + 12, 3);
      ahb(1, arx_pkg::A_CTRL, 1);
      path = 1;
      osel[2] = 2;
      osel[3] = 3;
      stb(3);
      bank(1);
      for (int d = 0; d < 16; d++) chk(emb_a[d], deemb_a[d]);
      // Fill the buffer until it refuses, then drain it.
      aes_nonpcm <= 8'h00;
      for (int k = 0; k < arx_pkg::FIFO_DEPTH; k++) begin
         word <= 24'(k);
         push <= 1'b1;
         @(posedge hclk);
         push <= 1'b0;
         do @(posedge hclk); while (aes_valid);
      end
      repeat (3) @(posedge hclk);
      chk(aes_ready, 0);
      stb(arx_pkg::FIFO_DEPTH);
      chk(aes_ready, 1);
      final_report;
   end
endmodule // testbench
bind arx_core arx_core_chk arx_core_chk_inst(.*);
`default_nettype wire
